//--- hw/can_mask_regs.vh
`ifndef CAN_MASK_REGS_VH
`define CAN_MASK_REGS_VH
`define MAILBOX_BYTE_ADDR   8'hA3
`define ID_MASK_ONE_ADDR    8'hC4
`define ID_MASK_TWO_ADDR    8'hC5
`define ID_MASK_THREE_ADDR  8'hC6
`define ID_MASK_FOUR_ADDR   8'hC7
`define M4_ID_LSB           3
`define M4_RTR_BIT          2
`define M4_RSVD_BIT         1
`define M4_IDE_BIT          0
`define ID_WIDTH            29
`define OBJ_BYTES           8
`define INDEX_LAST          3'h7
`define FIFO_DEPTH          16
`endif

//--- hw/byte_fifo.v
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk_sys,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_reg;
  reg [AW:0]      rd_reg;
  wire            full  = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  wire            empty = (wr_reg == rd_reg);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_reg[AW-1:0]];
  always @(posedge clk_sys) begin
    if (in_valid && !full)
      mem[wr_reg[AW-1:0]] <= in_data;
  end
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= {(AW+1){1'b0}};
      rd_reg <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full)
        wr_reg <= wr_reg + 1'b1;
      if (out_ready && !empty)
        rd_reg <= rd_reg + 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- hw/can_mask_data_port.v
`timescale 1ns/1ps
`default_nettype none
`include "can_mask_regs.vh"
module can_mask_data_port (
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire [7:0]  sfr_addr,
  input  wire [7:0]  sfr_wdata,
  input  wire        sfr_wr,
  input  wire        sfr_rd,
  output reg  [7:0]  sfr_rdata,
  input  wire        auto_inc_en,
  input  wire        index_load,
  input  wire [2:0]  index_value,
  input  wire [28:0] identifier_tag_bits,
  input  wire        remote_request_tag_value,
  input  wire        object_format_ext,
  input  wire [28:0] rx_identifier,
  input  wire        rx_remote_request,
  input  wire        rx_format_ext,
  input  wire        rx_check,
  output reg         rx_accept,
  output wire [28:0] tx_identifier,
  output wire        tx_remote_request,
  input  wire [7:0]  rx_byte_data,
  input  wire        rx_byte_valid,
  output wire        rx_byte_ready,
  output wire [2:0]  byte_index
);
  reg  [28:0] identifier_compare_mask;
  reg         remote_request_compare_mask;
  reg         format_compare_mask;
  reg  [7:0]  mailbox_byte [0:`OBJ_BYTES-1];
  reg  [2:0]  index_reg;
  reg  [2:0]  index_next;
  wire [7:0]  fifo_data;
  wire        fifo_valid;
  wire        cpu_touch;
  wire        match;

  function hit;
    input [7:0] a;
    input [7:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  assign cpu_touch = hit(sfr_addr, `MAILBOX_BYTE_ADDR) && (sfr_wr || sfr_rd);

  // incoming bytes queue while the processor is using the window or index_load is high
  byte_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH), .AW(4)) u_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_data   (rx_byte_data),
    .in_valid  (rx_byte_valid),
    .in_ready  (rx_byte_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (!cpu_touch && !index_load)
  );

  // masks have no reset on purpose: software must program them first
  always @(posedge clk_sys) begin
    if (sfr_wr && hit(sfr_addr, `ID_MASK_ONE_ADDR))
      identifier_compare_mask[28:21] <= sfr_wdata;
    if (sfr_wr && hit(sfr_addr, `ID_MASK_TWO_ADDR))
      identifier_compare_mask[20:13] <= sfr_wdata;
    if (sfr_wr && hit(sfr_addr, `ID_MASK_THREE_ADDR))
      identifier_compare_mask[12:5] <= sfr_wdata;
    if (sfr_wr && hit(sfr_addr, `ID_MASK_FOUR_ADDR)) begin
      identifier_compare_mask[4:0] <= sfr_wdata[7:`M4_ID_LSB];
      remote_request_compare_mask  <= sfr_wdata[`M4_RTR_BIT];
      format_compare_mask          <= sfr_wdata[`M4_IDE_BIT];
    end
    if (cpu_touch && sfr_wr)
      mailbox_byte[index_reg] <= sfr_wdata;
    else if (fifo_valid && !cpu_touch && !index_load)
      mailbox_byte[index_reg] <= fifo_data;
  end

  always @* begin
    index_next = index_reg;
    if (index_load)
      index_next = index_value;
    else if (auto_inc_en && (cpu_touch || fifo_valid))
      index_next = (index_reg == `INDEX_LAST) ? 3'h0 : index_reg + 3'h1;
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      index_reg <= 3'h0;
    else
      index_reg <= index_next;
  end
  assign byte_index = index_reg;

  // reserved bit 1 reads zero
  always @* begin
    case (sfr_addr)
      `MAILBOX_BYTE_ADDR:  sfr_rdata = mailbox_byte[index_reg];
      `ID_MASK_ONE_ADDR:   sfr_rdata = identifier_compare_mask[28:21];
      `ID_MASK_TWO_ADDR:   sfr_rdata = identifier_compare_mask[20:13];
      `ID_MASK_THREE_ADDR: sfr_rdata = identifier_compare_mask[12:5];
      `ID_MASK_FOUR_ADDR:  sfr_rdata = {identifier_compare_mask[4:0], remote_request_compare_mask,
                                        1'b0, format_compare_mask};
      default:             sfr_rdata = 8'h00;
    endcase
  end

  // masked-out bits compare true
  assign match = (((rx_identifier ^ identifier_tag_bits) & identifier_compare_mask) == 29'h0)
              && !(remote_request_compare_mask && (rx_remote_request != remote_request_tag_value))
              && !(format_compare_mask && (rx_format_ext != object_format_ext));

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      rx_accept <= 1'b0;
    else
      rx_accept <= rx_check && match;
  end

  // transmit path bypasses the masks
  assign tx_identifier     = identifier_tag_bits;
  assign tx_remote_request = remote_request_tag_value;
endmodule
`default_nettype wire

//--- tb/byte_src.sv
`timescale 1ns/1ps
`default_nettype none
module byte_src (
  input wire logic   clk_sys, rst_n, ready, go,
  output logic       valid,
  output logic [7:0] data
);
  logic [4:0] n;
  // idle data is inverted so a stale byte never looks fresh
  assign valid = go && n != 5'h14;
  assign data = valid ? {3'h0, n} : ~{3'h0, n};
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n) n <= 5'h00;
    else if (valid && ready) n <= n + 5'h01;
endmodule
`default_nettype wire

//--- tb/mask_port_props.sv
`timescale 1ns/1ps
`default_nettype none
module mask_port_props (
  input wire logic clk_sys, rst_n, sfr_wr, sfr_rd, auto_inc_en, index_load, rx_check,
  input wire logic rx_accept, remote_request_tag_value, tx_remote_request,
  input wire logic [7:0] sfr_addr, sfr_wdata, sfr_rdata,
  input wire logic [2:0] byte_index,
  input wire logic [28:0] identifier_tag_bits, tx_identifier
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire da = sfr_addr == 8'hA3 && (sfr_wr || sfr_rd);
  property p_tid; tx_identifier == identifier_tag_bits; endproperty
  a_tid: assert property (p_tid) else $error("tid");
  property p_trr; tx_remote_request == remote_request_tag_value; endproperty
  a_trr: assert property (p_trr) else $error("trr");
  property p_acc; rx_accept |-> $past(rx_check); endproperty
  a_acc: assert property (p_acc) else $error("acc");
  property p_inc; da && auto_inc_en && !index_load |=>
    byte_index == $past(byte_index) + 3'h1; endproperty
  a_inc: assert property (p_inc) else $error("inc");
  property p_hld; !auto_inc_en && !index_load |=> $stable(byte_index); endproperty
  a_hld: assert property (p_hld) else $error("hld");
  property p_rsv; sfr_addr == 8'hC7 |-> !sfr_rdata[1]; endproperty
  a_rsv: assert property (p_rsv) else $error("rsv");
  property p_rbk; sfr_wr && sfr_addr == 8'hC7 ##1 sfr_addr == 8'hC7 |->
    sfr_rdata == ($past(sfr_wdata) & 8'hFD); endproperty
  a_rbk: assert property (p_rbk) else $error("rbk");
  property p_unm; sfr_addr == 8'h10 |-> sfr_rdata == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unm");
  c_acc: cover property (rx_accept);
  c_wrap: cover property (byte_index == 3'h7 ##1 byte_index == 3'h0);
  c_rsv: cover property (sfr_addr == 8'hC7);
endmodule
bind can_mask_data_port mask_port_props props (.*);
`default_nettype wire

//--- tb/can_ext_id_mask_and_data_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module can_ext_id_mask_and_data_port_tb_top;
  logic clk_sys = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0, auto_inc_en = 1, index_load = 0, go = 0;
  logic rx_check = 0, rx_remote_request = 0, rx_format_ext = 0, rx_accept, tx_remote_request;
  logic remote_request_tag_value = 1, object_format_ext = 1, rx_byte_valid, rx_byte_ready;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata, rx_byte_data;
  logic [2:0] index_value = 0, byte_index;
  logic [28:0] identifier_tag_bits = 29'hFF, rx_identifier = 0, tx_identifier;
  int n_errors = 0, total_checks = 0;
  always #2 clk_sys = !clk_sys;
  can_mask_data_port uut (.*);
  byte_src src (.*, .data(rx_byte_data), .valid(rx_byte_valid), .ready(rx_byte_ready));
  task cmp(string n, logic [28:0] e, g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(logic [7:0] a, d);
    @(posedge clk_sys) #1 {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
    @(posedge clk_sys) #1 sfr_wr = 0;
  endtask
  task rd(logic [7:0] a, e);
    @(posedge clk_sys) #1 {sfr_addr, sfr_rd} = {a, 1'b1};
    #1 cmp("rd", e, sfr_rdata);
    @(posedge clk_sys) #1 sfr_rd = 0;
  endtask
  task flt(logic [28:0] i, logic r, f, e);
    @(posedge clk_sys) #1 {rx_identifier, rx_remote_request, rx_format_ext} = {i, r, f};
    rx_check = 1;
    @(posedge clk_sys) #1 rx_check = 0;
    cmp("acc", e, rx_accept);
  endtask
  task t_reg; // every mask written before filtering, reserved bit kept at zero
    for (int k = 4; k < 8; k++) wr({6'h31, 2'(k)}, k == 7 ? 8'hFD : 8'hFF);
    rd(8'hC7, 8'hFD);
    rd(8'hC4, 8'hFF);
    rd(8'h10, 8'h00);
    cmp("tx", 29'hFF, tx_identifier);
  endtask
  task t_flt;
    flt(29'hFF, 1, 1, 1);
    flt(29'hFE, 1, 1, 0);
    flt(29'hFF, 0, 1, 0);
    flt(29'hFF, 1, 0, 0);
    wr(8'hC7, 8'h00);
    flt(29'hE0, 0, 0, 1);
  endtask
  task t_data;
    for (int k = 0; k < 9; k++) wr(8'hA3, 8'(k));
    cmp("ix", 3'h1, byte_index);
    rd(8'hA3, 8'h01);
    @(posedge clk_sys) #1 {index_value, index_load} = {3'h0, 1'b1};
    @(posedge clk_sys) #1 index_load = 0;
    cmp("ix", 3'h0, byte_index);
    rd(8'hA3, 8'h08);
  endtask
  task t_fifo; // cpu keeps the window busy so the fifo must fill
    auto_inc_en = 0;
    @(posedge clk_sys) #1 {sfr_addr, sfr_rd, go} = {8'hA3, 1'b1, 1'b1};
    repeat (30) @(posedge clk_sys);
    #1 cmp("rdy", 0, rx_byte_ready);
    sfr_rd = 0;
    repeat (30) @(posedge clk_sys);
    rd(8'hA3, 8'h13);
    cmp("rdy", 1, rx_byte_ready);
  endtask
  task stop_test;
    if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    #1 rst_n = 1;
    t_reg;
    t_flt;
    t_data;
    t_fifo;
    stop_test;
  end
  initial begin
    #4000;
    n_errors++;
    stop_test;
  end
endmodule
`default_nettype wire
